// ---- design/jlct_pkg.sv ----
// Constants, types and helpers of the link control bank.
package jlct_pkg;

   // ==========================================================
   // Register port geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int TEST_W = 5;
   localparam int MODE_W = 6;
   localparam int LANES  = 8;

   // ==========================================================
   // Register offsets
   localparam logic [ADDR_W-1:0] OFS_LINK_ENABLE  = 12'h200;
   localparam logic [ADDR_W-1:0] OFS_MODE         = 12'h201;
   localparam logic [ADDR_W-1:0] OFS_SYNC_REQ     = 12'h203;
   localparam logic [ADDR_W-1:0] OFS_LINK_CONTROL = 12'h204;
   localparam logic [ADDR_W-1:0] OFS_TEST         = 12'h205;
   localparam logic [ADDR_W-1:0] OFS_DID          = 12'h206;
   localparam logic [ADDR_W-1:0] OFS_FRAME_END_CHARACTER        = 12'h207;
   localparam logic [ADDR_W-1:0] OFS_TS_RX        = 12'h20A;

   // ==========================================================
   // Reset values
   localparam logic [DATA_W-1:0] RST_LINK_ENABLE  = 8'h01;
   localparam logic [DATA_W-1:0] RST_MODE         = 8'h00;
   localparam logic [DATA_W-1:0] RST_SYNC_REQ     = 8'h01;
   localparam logic [DATA_W-1:0] RST_LINK_CONTROL = 8'h03;
   localparam logic [DATA_W-1:0] RST_TEST         = 8'h00;
   localparam logic [DATA_W-1:0] RST_DID          = 8'h00;
   localparam logic [DATA_W-1:0] RST_FRAME_END_CHARACTER        = 8'h00;
   localparam logic [DATA_W-1:0] RST_TS_RX        = 8'h00;

   // ==========================================================
   // Field positions
   localparam int CTL_SCR_BIT   = 0;
   localparam int CTL_FMT_BIT   = 1;
   localparam int CTL_SYNC_LSB  = 2;
   localparam int CTL_UPPER_BIT = 4;
   localparam int MODE_64B_BIT  = 5;
   localparam int UPPER_SHIFT   = 4;
   localparam logic [3:0] UPPER_MAX_LANES = 4'h4;

   // ==========================================================
   // Sync source, test codes and fixed patterns
   typedef enum logic [1:0] {
      SYNC_SE   = 2'b00,
      SYNC_TS   = 2'b01,
      SYNC_NONE = 2'b10
   } jlct_sync_src_e;

   localparam logic [TEST_W-1:0] TP_K285      = 5'h07;
   localparam logic [TEST_W-1:0] TP_RPAT      = 5'h09;
   localparam logic [TEST_W-1:0] TP_D215      = 5'h06;
   localparam logic [TEST_W-1:0] TP_LOW       = 5'h0A;
   localparam logic [TEST_W-1:0] TP_HIGH      = 5'h0B;
   localparam logic [TEST_W-1:0] TP_RSV12     = 5'h0C;
   localparam logic [TEST_W-1:0] TP_CLOCK     = 5'h0F;
   localparam logic [TEST_W-1:0] TP_K287      = 5'h10;
   localparam logic [TEST_W-1:0] TP_RSV_FIRST = 5'h11;
   localparam logic [15:0] PAT_LOW   = 16'h0000;
   localparam logic [15:0] PAT_HIGH  = 16'hFFFF;
   localparam logic [15:0] PAT_CLOCK = 16'h00FF;
   localparam logic [15:0] PAT_D215  = 16'hB5B5;

   // End-of-frame comma bytes.
   localparam logic [7:0] K28_7 = 8'hFC;
   localparam logic [7:0] K28_1 = 8'h3C;
   localparam logic [7:0] K28_5 = 8'hBC;

   // ==========================================================
   // Controller command and status layout
   localparam logic [3:0] AVS_OFS_CMD    = 4'h0;
   localparam logic [3:0] AVS_OFS_STATUS = 4'h4;
   localparam int CMD_DATA_LSB = 12;
   localparam int CMD_WR_BIT   = 24;
   localparam int CMD_RD_BIT   = 25;
   localparam int ST_BUSY_BIT  = 0;
   localparam int ST_ERR_BIT   = 1;
   localparam int ST_RD_LSB    = 8;

   // Lane count of an output mode: two low mode bits give 1, 2, 4 or 8.
   function automatic logic [3:0] lanes_of_mode(input logic [MODE_W-1:0] mode);
      lanes_of_mode = 4'h1 << mode[1:0];
   endfunction

   // Modes with the top mode bit set use the 64B/66B link layer.
   function automatic logic is_64b(input logic [MODE_W-1:0] mode);
      is_64b = mode[MODE_64B_BIT];
   endfunction

endpackage

// ---- design/jlct_if.sv ----
// Register access carrier between controller and device.
interface jlct_if
   import jlct_pkg::*;
();
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic              wr;
   logic              rd;
   logic [DATA_W-1:0] rdata;
   logic              ack;

   modport dev (input addr, wdata, wr, rd, output rdata, ack);
   modport ctl (output addr, wdata, wr, rd, input rdata, ack);
endinterface

// ---- design/jlct_sync2.sv ----
// Two flip-flop synchroniser for pin levels.
module jlct_sync2 #(
   parameter int W = 1
) (
   input  wire logic         i_clk,
   input  wire logic         i_arst_n,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // ==========================================================
   // The first stage feeds only the second stage.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         meta_q <= '1;
         sync_q <= '1;
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;
endmodule

// ---- design/jlct_device.sv ----
// Link device end: register bank and transmitter settings.
//
// Behaviour
// - Upper select clear: lanes 0 to L-1.
// - Upper select set: lanes 4 to 4+L-1.
// - Upper lanes only with modes of L<=4.
// - Sync source: pin, timestamp input, or none.
// - Sample format: offset binary or two's complement.
// - 8B/10B scrambling follows scrambler enable bit.
// - 64B/66B modes always scramble, ignore bit.
// - Ramp, transport, D21.5, held levels, clock pattern.
// - Codes 7, 8, 9, 16 need 8B/10B.
// - Codes 12 and 17-31 never programmed.
// - Identifier sent as ILA_DEVICE_IDENTIFIER in ILA.
// - Settings change only while link disabled.
// - Link disabled: reset, power down, gate clocks.
// - Frame character code picks end-of-frame comma.
// - Software sync bit 0 cleared requests synchronization.
module jlct_device
   import jlct_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_arst_n,
   jlct_if.dev                    bus,
   input  wire logic              i_sync_pin_n,
   input  wire logic              i_timestamp_n,
   output logic [LANES-1:0]       o_lane_en,
   output logic                   o_link_rst,
   output logic                   o_ser_pwrdn,
   output logic                   o_ser_clk_en,
   output logic                   o_sync_req,
   output logic                   o_twos_compl,
   output logic                   o_scramble,
   output logic                   o_enc_64b,
   output logic [TEST_W-1:0]      o_test_pattern,
   output logic                   o_fixed_pat_en,
   output logic [15:0]            o_fixed_pat,
   output logic [DATA_W-1:0]      o_ila_did,
   output logic [7:0]             o_frame_char
);

   // ==========================================================
   // Register storage
   logic                link_enable_q;
   logic [MODE_W-1:0]   mode_q;
   logic                sw_sync_n_q;
   logic                upper_q;
   logic [1:0]          sync_sel_q;
   logic                fmt_q;
   logic                scr_q;
   logic [TEST_W-1:0]   test_q;
   logic [DATA_W-1:0]   did_q;
   logic [1:0]          frame_end_character_q;
   logic                ts_rx_en_q;
   logic [DATA_W-1:0]   rdata_q;
   logic                ack_q;
   logic [1:0]          pins_s;
   logic                sel_sync_n;
   logic [3:0]          lanes;
   logic [LANES-1:0]    lane_mask;
   logic                fixed_en;
   logic [15:0]         fixed_word;
   logic [7:0]          comma;

   // Readback; reserved bits and unmapped offsets read zero.
   function automatic logic [DATA_W-1:0] read_reg(input logic [ADDR_W-1:0] a);
      read_reg = 8'h00;
      case (a)
         OFS_LINK_ENABLE:  read_reg = {7'h00, link_enable_q};
         OFS_MODE:         read_reg = {2'h0, mode_q};
         OFS_SYNC_REQ:     read_reg = {7'h00, sw_sync_n_q};
         OFS_LINK_CONTROL: read_reg = {3'h0, upper_q, sync_sel_q, fmt_q, scr_q};
         OFS_TEST:         read_reg = {3'h0, test_q};
         OFS_DID:          read_reg = did_q;
         OFS_FRAME_END_CHARACTER:        read_reg = {6'h00, frame_end_character_q};
         OFS_TS_RX:        read_reg = {7'h00, ts_rx_en_q};
         default:          read_reg = 8'h00;
      endcase
   endfunction

   // ==========================================================
   // Register writes; the controller holds settings while the link runs.
   // software-side ordering relied on
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         link_enable_q <= RST_LINK_ENABLE[0];
         mode_q        <= RST_MODE[MODE_W-1:0];
         sw_sync_n_q   <= RST_SYNC_REQ[0];
         upper_q       <= RST_LINK_CONTROL[CTL_UPPER_BIT];
         sync_sel_q    <= RST_LINK_CONTROL[CTL_SYNC_LSB +: 2];
         fmt_q         <= RST_LINK_CONTROL[CTL_FMT_BIT];
         scr_q         <= RST_LINK_CONTROL[CTL_SCR_BIT];
         test_q        <= RST_TEST[TEST_W-1:0];
         did_q         <= RST_DID;
         frame_end_character_q       <= RST_FRAME_END_CHARACTER[1:0];
         ts_rx_en_q    <= RST_TS_RX[0];
      end else if (bus.wr) begin
         case (bus.addr)
            OFS_LINK_ENABLE: link_enable_q <= bus.wdata[0];
            OFS_MODE:        mode_q        <= bus.wdata[MODE_W-1:0];
            OFS_SYNC_REQ:    sw_sync_n_q   <= bus.wdata[0];
            OFS_LINK_CONTROL: begin
               upper_q    <= bus.wdata[CTL_UPPER_BIT];
               sync_sel_q <= bus.wdata[CTL_SYNC_LSB +: 2];
               fmt_q      <= bus.wdata[CTL_FMT_BIT];
               scr_q      <= bus.wdata[CTL_SCR_BIT];
            end
            OFS_TEST:  test_q     <= bus.wdata[TEST_W-1:0];
            OFS_DID:   did_q      <= bus.wdata;
            OFS_FRAME_END_CHARACTER: frame_end_character_q    <= bus.wdata[1:0];
            OFS_TS_RX: ts_rx_en_q <= bus.wdata[0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Answer one cycle after any request, read data beside it.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ack_q   <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         ack_q   <= bus.wr | bus.rd;
         rdata_q <= bus.rd ? read_reg(bus.addr) : 8'h00;
      end
   end

   assign bus.ack   = ack_q;
   assign bus.rdata = rdata_q;

   // ==========================================================
   // Sync pins are asynchronous to the register clock.
   jlct_sync2 #(
      .W (2)
   ) u_pin_sync (
      .i_clk     (i_clk),
      .i_arst_n  (i_arst_n),
      .i_async   ({i_timestamp_n, i_sync_pin_n}),
      .o_sync    (pins_s)
   );

   always_comb begin
      case (jlct_sync_src_e'(sync_sel_q))
         SYNC_SE:   sel_sync_n = pins_s[0];
         SYNC_TS:   sel_sync_n = pins_s[1] | ~ts_rx_en_q; // Receiver off: no request.
         SYNC_NONE: sel_sync_n = 1'b1;
         default:   sel_sync_n = 1'b1;
      endcase
   end

   // ==========================================================
   // Lane map; a wide mode with upper select just truncates.
   // lower or upper lane map
   assign lanes     = lanes_of_mode(mode_q);
   assign lane_mask = LANES'((9'h001 << lanes) - 9'h001)
                      << (upper_q ? UPPER_SHIFT : 0);

   always_comb begin
      fixed_en   = 1'b1;
      fixed_word = PAT_LOW;
      case (test_q)
         TP_D215:  fixed_word = PAT_D215;
         TP_LOW:   fixed_word = PAT_LOW;
         TP_HIGH:  fixed_word = PAT_HIGH;
         TP_CLOCK: fixed_word = PAT_CLOCK;
         default:  fixed_en   = 1'b0;
      endcase
   end

   // end-of-frame comma; reserved code gives K28.7
   always_comb begin
      case (frame_end_character_q)
         2'h1:    comma = K28_1;
         2'h2:    comma = K28_5;
         default: comma = K28_7;
      endcase
   end

   // ==========================================================
   // Settings towards the transmitter, all from flip-flops.
   // disabled link held in reset
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_link_rst   <= 1'b1;
         o_ser_pwrdn  <= 1'b1;
         o_ser_clk_en <= 1'b0;
         o_lane_en    <= '0;
      end else begin
         o_link_rst   <= ~link_enable_q;
         o_ser_pwrdn  <= ~link_enable_q;
         o_ser_clk_en <= link_enable_q;
         o_lane_en    <= link_enable_q ? lane_mask : '0;
      end
   end

   // Sync request and data format settings.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_sync_req   <= 1'b0;
         o_twos_compl <= 1'b1;
         o_scramble   <= 1'b1;
         o_enc_64b    <= 1'b0;
      end else begin
         o_sync_req   <= ~(sel_sync_n & sw_sync_n_q);
         o_twos_compl <= fmt_q;
         o_scramble   <= is_64b(mode_q) | scr_q;
         o_enc_64b    <= is_64b(mode_q);
      end
   end

   // Test pattern, identifier and frame character.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_test_pattern <= '0;
         o_fixed_pat_en <= 1'b0;
         o_fixed_pat    <= PAT_LOW;
         o_ila_did      <= RST_DID;
         o_frame_char   <= K28_7;
      end else begin
         // test code passed to lane generator
         o_test_pattern <= test_q;
         o_fixed_pat_en <= fixed_en;
         o_fixed_pat    <= fixed_word;
         o_ila_did      <= did_q;
         o_frame_char   <= comma;
      end
   end

endmodule

// ---- design/jlct_host.sv ----
// Controller end: Avalon-MM command port to the device registers.
module jlct_host
   import jlct_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_arst_n,
   input  wire logic [3:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   output logic [31:0]      o_avs_readdata,
   output logic             o_avs_waitrequest,
   jlct_if.ctl              bus
);

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ISSUE = 2'b01,
      ST_WAIT  = 2'b10
   } jlct_host_st_e;

   jlct_host_st_e     st_q;
   logic              wait_q;
   logic              err_q;
   logic              en_shadow_q;
   logic [MODE_W-1:0] mode_shadow_q;
   logic [ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] wdata_q;
   logic              dir_wr_q;
   logic              wr_q;
   logic              rd_q;
   logic [DATA_W-1:0] last_rd_q;
   logic              take;
   logic              cmd_go;
   logic              cmd_wr;
   logic [ADDR_W-1:0] cmd_addr;
   logic [DATA_W-1:0] cmd_data;
   logic              bad;

   // ==========================================================
   // Waitrequest drops a cycle after a request; commands act at the next edge, while it is low.
   assign take     = (i_avs_read | i_avs_write) & wait_q;
   assign cmd_wr   = i_avs_writedata[CMD_WR_BIT];
   assign cmd_addr = i_avs_writedata[ADDR_W-1:0];
   assign cmd_data = i_avs_writedata[CMD_DATA_LSB +: DATA_W];
   assign cmd_go   = ~wait_q & i_avs_write & (i_avs_address == AVS_OFS_CMD)
                     & (st_q == ST_IDLE)
                     & (cmd_wr | i_avs_writedata[CMD_RD_BIT]);

   // Writes beyond the device's usage limits are refused.
   always_comb begin
      bad = 1'b0;
      if (cmd_wr) begin
         if (en_shadow_q && cmd_addr != OFS_LINK_ENABLE
             && cmd_addr != OFS_SYNC_REQ)
            bad = 1'b1;
         if (cmd_addr == OFS_LINK_CONTROL && cmd_data[CTL_UPPER_BIT]
             && lanes_of_mode(mode_shadow_q) > UPPER_MAX_LANES)
            bad = 1'b1;
         if (cmd_addr == OFS_TEST) begin
            if (cmd_data[TEST_W-1:0] == TP_RSV12
                || cmd_data[TEST_W-1:0] >= TP_RSV_FIRST)
               bad = 1'b1;
            if (is_64b(mode_shadow_q)
                && ((cmd_data[TEST_W-1:0] >= TP_K285 && cmd_data[TEST_W-1:0] <= TP_RPAT)
                    || cmd_data[TEST_W-1:0] == TP_K287))
               bad = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wait_q         <= 1'b1;
         o_avs_readdata <= 32'h0000_0000;
      end else begin
         wait_q         <= ~take;
         o_avs_readdata <= (take & i_avs_read & i_avs_address == AVS_OFS_STATUS)
                           ? {16'h0000, last_rd_q, 6'h00, err_q, st_q != ST_IDLE}
                           : 32'h0000_0000;
      end
   end

   assign o_avs_waitrequest = wait_q;

   // ==========================================================
   // Error flag: a new refusal wins over a write-one clear.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         err_q <= 1'b0;
      end else if (cmd_go && bad) begin
         err_q <= 1'b1;
      end else if (!wait_q && i_avs_write && i_avs_address == AVS_OFS_STATUS
                   && i_avs_writedata[ST_ERR_BIT]) begin
         err_q <= 1'b0;
      end
   end

   // ==========================================================
   // Access sequencer: one pulse out, then await the answer.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st_q      <= ST_IDLE;
         addr_q    <= '0;
         wdata_q   <= '0;
         dir_wr_q  <= 1'b0;
         wr_q      <= 1'b0;
         rd_q      <= 1'b0;
         last_rd_q <= '0;
      end else begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         case (st_q)
            ST_IDLE: begin
               if (cmd_go && !bad) begin
                  addr_q   <= cmd_addr;
                  wdata_q  <= cmd_data;
                  dir_wr_q <= cmd_wr;
                  wr_q     <= cmd_wr;
                  rd_q     <= ~cmd_wr;
                  st_q     <= ST_ISSUE;
               end
            end
            ST_ISSUE: st_q <= ST_WAIT;
            ST_WAIT: begin
               if (bus.ack) begin
                  if (!dir_wr_q) begin
                     last_rd_q <= bus.rdata;
                  end
                  st_q <= ST_IDLE;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // Shadows of link enable and mode, from issued writes.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         en_shadow_q   <= RST_LINK_ENABLE[0];
         mode_shadow_q <= RST_MODE[MODE_W-1:0];
      end else if (wr_q) begin
         if (addr_q == OFS_LINK_ENABLE) begin
            en_shadow_q <= wdata_q[0];
         end
         if (addr_q == OFS_MODE) begin
            mode_shadow_q <= wdata_q[MODE_W-1:0];
         end
      end
   end

   assign bus.addr  = addr_q;
   assign bus.wdata = wdata_q;
   assign bus.wr    = wr_q;
   assign bus.rd    = rd_q;

endmodule

// ---- verif/jlct_monitor.sv ----
// Concurrent checks on the register carrier.
module jlct_monitor
   import jlct_pkg::*;
(
   input wire logic              i_clk,
   input wire logic              i_arst_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic              wr,
   input wire logic              rd,
   input wire logic [DATA_W-1:0] rdata,
   input wire logic              ack
);
   logic              en_q;
   logic [MODE_W-1:0] mode_q;
   logic              cfg_wr;

   // ==========================================================
   // Shadows of enable and mode from the writes that went out.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         en_q <= 1'b1;
      end else if (wr && addr == OFS_LINK_ENABLE) begin
         en_q <= wdata[0];
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         mode_q <= '0;
      end else if (wr && addr == OFS_MODE) begin
         mode_q <= wdata[MODE_W-1:0];
      end
   end

   // Settings that wait for a disabled link.
   assign cfg_wr = wr && (addr == OFS_MODE || addr == OFS_TS_RX ||
                          (addr >= OFS_LINK_CONTROL && addr <= OFS_FRAME_END_CHARACTER));

   // ==========================================================
   // Assertions.
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);

   AST_ACK_NEXT: assert property ((wr || rd) |=> ack && !(wr || rd))
      else $error("request not answered");
   AST_ACK_CAUSE: assert property (ack |-> $past(wr || rd))
      else $error("answer without request");
   AST_RD_WR_EXCL: assert property (!(wr && rd))
      else $error("read and write together");
   AST_RDATA_IDLE: assert property (!ack |-> rdata == 8'h00)
      else $error("read data outside answer");
   AST_UNMAPPED_RD: assert property (rd && addr[11:4] != 8'h20 |=> rdata == 8'h00)
      else $error("unmapped read nonzero");
   AST_CFG_DISABLED: assert property (cfg_wr |-> !en_q)
      else $error("setting written while enabled");
   AST_UPPER_NARROW: assert property (wr && addr == OFS_LINK_CONTROL && wdata[4]
                                      |-> mode_q[1:0] != 2'h3)
      else $error("upper lanes with wide mode");
   AST_RSV_CODE: assert property (wr && addr == OFS_TEST
                                  |-> wdata[4:0] != 5'h0C && wdata[4:0] < 5'h11)
      else $error("reserved test code");
   AST_64B_CODES: assert property (wr && addr == OFS_TEST && mode_q[MODE_64B_BIT]
                                   |-> !(wdata[4:0] inside {5'h07, 5'h08, 5'h09, 5'h10}))
      else $error("8b10b-only code in 64b66b mode");

   COV_READ: cover property (ack && $past(rd));
   COV_TEST_WR: cover property (wr && addr == OFS_TEST);
   COV_DISABLE: cover property (wr && addr == OFS_LINK_ENABLE && !wdata[0]);
endmodule

// ---- verif/tb_jesd_link_control_test.sv ----
// Bench joining controller and device over the carrier.
module tb_jesd_link_control_test
   import jlct_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic             clk = 1'b0;
   logic             arst_n = 1'b0;
   logic [3:0]       av_addr = 4'h0;
   logic             av_rd = 1'b0;
   logic             av_wr = 1'b0;
   logic [31:0]      av_wdata = 32'h0;
   logic [31:0]      av_rdata;
   logic             av_wait;
   logic             sync_pin_n = 1'b1;
   logic             ts_n = 1'b1;
   logic [LANES-1:0] lane_en;
   logic             link_rst, pwrdn, clk_en, sync_req, twos, scrambler_enable, enc64, fix_en;
   logic [4:0]       tp;
   logic [15:0]      fix;
   logic [7:0]       ila_device_identifier, fch;
   int               n_mismatch = 0;
   int               check_count = 0;

   // ==========================================================
   // Both ends, the carrier and its monitor.
   jlct_if bus_if ();
   jlct_host jlct_host_inst (.i_clk(clk), .i_arst_n(arst_n), .i_avs_address(av_addr),
      .i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_writedata(av_wdata),
      .o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait), .bus(bus_if));
   jlct_device jlct_device_inst (.i_clk(clk), .i_arst_n(arst_n), .bus(bus_if),
      .i_sync_pin_n(sync_pin_n), .i_timestamp_n(ts_n), .o_lane_en(lane_en),
      .o_link_rst(link_rst), .o_ser_pwrdn(pwrdn), .o_ser_clk_en(clk_en),
      .o_sync_req(sync_req), .o_twos_compl(twos), .o_scramble(scrambler_enable), .o_enc_64b(enc64),
      .o_test_pattern(tp), .o_fixed_pat_en(fix_en), .o_fixed_pat(fix),
      .o_ila_did(ila_device_identifier), .o_frame_char(fch));
   jlct_monitor jlct_monitor_inst (.i_clk(clk), .i_arst_n(arst_n), .addr(bus_if.addr),
      .wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata),
      .ack(bus_if.ack));

   // Clock of 100 ns period.
   always #50 clk = ~clk;

   // ==========================================================
   // Verdict, comparison and bus tasks.
   task automatic tally_and_finish;
      if (n_mismatch == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask

   // One Avalon transfer, held until waitrequest is seen low.
   task automatic avm(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      av_addr <= a;
      av_wdata <= d;
      av_wr <= w;
      av_rd <= ~w;
      do begin
         @(posedge clk);
         n++;
      end while (av_wait !== 1'b0 && n < 50);
      q = av_rdata;
      av_wr <= 1'b0;
      av_rd <= 1'b0;
      if (av_wait !== 1'b0) begin
         n_mismatch++;
         tally_and_finish();
      end
   endtask

   // Device command, then poll status until idle.
   task automatic acc(input logic r, input logic [11:0] ofs, input logic [7:0] d,
                      output logic [31:0] st);
      int n;
      n = 0;
      avm(1'b1, AVS_OFS_CMD, {6'h00, r, ~r, 4'h0, d, ofs}, st);
      do begin
         avm(1'b0, AVS_OFS_STATUS, 32'h0, st);
         n++;
      end while (st[ST_BUSY_BIT] !== 1'b0 && n < 20);
      if (st[ST_BUSY_BIT] !== 1'b0) begin
         n_mismatch++;
         tally_and_finish();
      end
   endtask

   // Device write; a refusal shows as the error flag, then cleared.
   task automatic dev_wr(input logic [11:0] ofs, input logic [7:0] d, input logic err);
      logic [31:0] st;
      acc(1'b0, ofs, d, st);
      chk(16'(st[ST_ERR_BIT]), 16'(err));
      if (st[ST_ERR_BIT] === 1'b1) avm(1'b1, AVS_OFS_STATUS, 32'h2, st);
   endtask

   task automatic dev_rd(input logic [11:0] ofs, input logic [7:0] exp);
      logic [31:0] st;
      acc(1'b1, ofs, 8'h00, st);
      chk(16'(st[15:8]), 16'(exp));
   endtask

   // ==========================================================
   // Scenarios.
   task automatic t_reset;
      dev_rd(OFS_LINK_CONTROL, 8'h03);
      dev_rd(OFS_DID, 8'h00);
      chk(16'({link_rst, pwrdn, clk_en, lane_en}), 16'h0101);
      chk(16'({twos, scrambler_enable}), 16'h3);
      chk(16'(fch), 16'(K28_7));
   endtask

   task automatic t_enable;
      dev_wr(OFS_DID, 8'h5A, 1'b1);
      dev_wr(OFS_LINK_ENABLE, 8'h00, 1'b0);
      chk(16'({link_rst, pwrdn, clk_en}), 16'h6);
      dev_rd(12'h2FF, 8'h00);
      dev_rd(OFS_DID, 8'h00);
   endtask

   // All lane counts, both maps; wide mode refuses upper lanes.
   task automatic t_lanes;
      logic [7:0] exp;
      for (int m = 0; m < 4; m++) begin
         for (int u = 0; u < 2; u++) begin
            exp = 8'(((16'h1 << (1 << m)) - 16'h1) << (4 * u));
            dev_wr(OFS_MODE, 8'(m), 1'b0);
            dev_wr(OFS_LINK_CONTROL, 8'(3 + 16 * u), 1'(m == 3 && u == 1));
            dev_wr(OFS_LINK_ENABLE, 8'h01, 1'b0);
            if (!(m == 3 && u == 1)) chk(16'(lane_en), 16'(exp));
            dev_wr(OFS_LINK_ENABLE, 8'h00, 1'b0);
         end
      end
   endtask

   task automatic t_test;
      logic        rsv;
      logic        fx;
      logic [15:0] pat;
      dev_wr(OFS_MODE, 8'h00, 1'b0);
      dev_wr(OFS_LINK_CONTROL, 8'h00, 1'b0);
      chk(16'({twos, scrambler_enable}), 16'h0);
      dev_wr(OFS_MODE, 8'h20, 1'b0);
      chk(16'({enc64, scrambler_enable}), 16'h3);
      for (int c = 7; c < 10; c++) dev_wr(OFS_TEST, 8'(c), 1'b1);
      dev_wr(OFS_TEST, 8'(TP_K287), 1'b1);
      dev_wr(OFS_MODE, 8'h00, 1'b0);
      for (int c = 0; c < 32; c++) begin
         rsv = (c == 12 || c > 16);
         fx = (c == 6 || c == 10 || c == 11 || c == 15);
         case (c)
            6: pat = PAT_D215;
            11: pat = 16'hFFFF;
            15: pat = 16'h00FF;
            default: pat = 16'h0000;
         endcase
         dev_wr(OFS_TEST, 8'(c), rsv);
         if (!rsv) begin
            chk(16'(tp), 16'(c));
            chk(16'(fix_en), 16'(fx));
            if (fx) chk(fix, pat);
         end
      end
   endtask

   task automatic t_did;
      logic [7:0] fc[4];
      fc = '{K28_7, K28_1, K28_5, K28_7};
      dev_wr(OFS_DID, 8'hA5, 1'b0);
      chk(16'(ila_device_identifier), 16'h00A5);
      for (int i = 0; i < 4; i++) begin
         dev_wr(OFS_FRAME_END_CHARACTER, 8'(i), 1'b0);
         chk(16'(fch), 16'(fc[i]));
      end
   endtask

   // Pin, timestamp and software sync; pins need three edges.
   task automatic t_sync;
      dev_wr(OFS_LINK_CONTROL, 8'h03, 1'b0);
      sync_pin_n <= 1'b0;
      repeat (4) @(posedge clk);
      chk(16'(sync_req), 16'h1);
      dev_wr(OFS_LINK_CONTROL, 8'h0B, 1'b0);
      chk(16'(sync_req), 16'h0);
      dev_wr(OFS_SYNC_REQ, 8'h00, 1'b0);
      chk(16'(sync_req), 16'h1);
      dev_wr(OFS_SYNC_REQ, 8'h01, 1'b0);
      sync_pin_n <= 1'b1;
      ts_n <= 1'b0;
      dev_wr(OFS_LINK_CONTROL, 8'h07, 1'b0);
      chk(16'(sync_req), 16'h0);
      dev_wr(OFS_TS_RX, 8'h01, 1'b0);
      chk(16'(sync_req), 16'h1);
   endtask

   // Main sequence: reset, scenarios, verdict.
   initial begin
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      t_reset();
      t_enable();
      t_lanes();
      t_test();
      t_did();
      t_sync();
      tally_and_finish();
   end
endmodule
